// File: design/irc_pkg.sv
/*
 * Shared constants and types for the IO read home collision resolver:
 * transaction codes, response codes, resolver actions and the granule
 * size used to decide an address collision.
 * Assumes a 32-bit transaction address and one outstanding request.
 */
package irc_pkg;

   // ------------------------------------------------------------------
   // Widths and granule
   // ------------------------------------------------------------------
   localparam int ADDR_W = 32;
   localparam int GRAN_BITS = 5; // 32-byte coherence granule

   // ------------------------------------------------------------------
   // Incoming transaction codes
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      TXN_READ_HOME         = 4'h0,
      TXN_IREAD_HOME        = 4'h1,
      TXN_READ_OWNER        = 4'h2,
      TXN_READ_TO_OWN_HOME  = 4'h3,
      TXN_READ_TO_OWN_OWNER = 4'h4,
      TXN_DKILL_HOME        = 4'h5,
      TXN_DKILL_SHARER      = 4'h6,
      TXN_CASTOUT           = 4'h7,
      TXN_TLBIE             = 4'h8,
      TXN_TLBSYNC           = 4'h9,
      TXN_IKILL_HOME        = 4'ha,
      TXN_IKILL_SHARER      = 4'hb,
      TXN_FLUSH             = 4'hc,
      TXN_IO_READ_HOME      = 4'hd,
      TXN_IO_READ_OWNER     = 4'he,
      TXN_UNKNOWN           = 4'hf
   } irc_txn_e;

   // ------------------------------------------------------------------
   // Response codes and resolver actions
   // ------------------------------------------------------------------
   typedef enum logic [1:0] {
      RSP_DONE      = 2'h0,
      RSP_ERROR     = 2'h1,
      RSP_NOT_OWNER = 2'h2,
      RSP_PASS      = 2'h3  // No collision, normal path answers
   } irc_rsp_e;

   typedef enum logic [2:0] {
      ACT_PASS      = 3'h0,
      ACT_ERROR     = 3'h1,
      ACT_NOT_OWNER = 3'h2,
      ACT_FWD       = 3'h3,
      ACT_WAIT_FWD  = 3'h4
   } irc_act_e;

   // Reset values
   localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;

   // Same coherence granule test
   function automatic logic same_granule(input logic [ADDR_W-1:0] a,
                                         input logic [ADDR_W-1:0] b);
      return a[ADDR_W-1:GRAN_BITS] == b[ADDR_W-1:GRAN_BITS];
   endfunction

endpackage

// File: design/irc_dec_if.sv
/*
 * Carrier between the resolver and its decision table.
 * Assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
interface irc_dec_if;
   irc_pkg::irc_txn_e in_type;
   logic participant;
   logic collide;
   irc_pkg::irc_act_e action;

   modport req (output in_type, output participant, output collide,
                input action);
   modport tbl (input in_type, input participant, input collide,
                output action);
endinterface

// File: design/irc_decide.sv
/*
 * Decision table: maps an incoming transaction that meets an outstanding
 * IO read home request to an action, for either role of the element.
 * Assumes the caller has already compared addresses (collide).
 */
`timescale 1ns/1ps
module irc_decide (
   irc_dec_if.tbl dec
);

   // ------------------------------------------------------------------
   // Table lookup
   // ------------------------------------------------------------------
   // Broadcast kinds are forwarded on a collision, whatever the role
   always_comb begin
      dec.action = irc_pkg::ACT_ERROR;
      if (!dec.collide) begin
         dec.action = irc_pkg::ACT_PASS;
      end else if (dec.participant) begin
         case (dec.in_type)
            irc_pkg::TXN_TLBIE,
            irc_pkg::TXN_TLBSYNC: begin
               dec.action = irc_pkg::ACT_FWD;
            end
            irc_pkg::TXN_IKILL_SHARER: begin
               dec.action = irc_pkg::ACT_FWD;
            end
            irc_pkg::TXN_IO_READ_OWNER: begin
               dec.action = irc_pkg::ACT_NOT_OWNER;
            end
            irc_pkg::TXN_READ_OWNER,
            irc_pkg::TXN_READ_TO_OWN_OWNER: begin
               dec.action = irc_pkg::ACT_NOT_OWNER;
            end
            irc_pkg::TXN_DKILL_SHARER: begin
               dec.action = irc_pkg::ACT_WAIT_FWD;
            end
            default: begin
               // Homes, castout, flush, IO read home
               dec.action = irc_pkg::ACT_ERROR;
            end
         endcase
      end else begin
         case (dec.in_type)
            irc_pkg::TXN_TLBIE,
            irc_pkg::TXN_TLBSYNC: begin
               dec.action = irc_pkg::ACT_FWD;
            end
            irc_pkg::TXN_IKILL_SHARER: begin
               dec.action = irc_pkg::ACT_FWD;
            end
            default: begin
               dec.action = irc_pkg::ACT_ERROR;
            end
         endcase
      end
   end

endmodule

// File: design/irc_resolver.sv
/*
 * Collision resolver for an outstanding IO read home request. Takes one
 * incoming transaction at a time, compares it with the outstanding
 * address, and answers PASS, ERROR or NOT_OWNER, or forwards it to the local
 * processor and answers DONE once the processor has finished.
 * Assumes all inputs come from logic on clk; participant is a static
 * role setting; out_final pulses once when the outstanding request ends.
 */
`timescale 1ns/1ps
module irc_resolver (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic participant,
   input wire logic out_valid,
   input wire logic [31:0] out_addr,
   input wire logic out_final,
   input wire logic out_final_retry,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [3:0] in_type,
   input wire logic [31:0] in_addr,
   output logic fwd_valid,
   output logic [3:0] fwd_type,
   output logic [31:0] fwd_addr,
   input wire logic fwd_done,
   output logic rsp_valid,
   output logic [1:0] rsp_code,
   output logic rsp_data_ret
);

   // ------------------------------------------------------------------
   // State and registers
   // ------------------------------------------------------------------
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_WAIT = 4'b0010,
      ST_FWD  = 4'b0100,
      ST_RESP = 4'b1000
   } irc_state_e;

   irc_state_e state, next_state;
   logic [3:0] next_fwd_type;
   logic [31:0] next_fwd_addr;
   logic next_rsp_valid;
   logic [1:0] next_rsp_code;
   logic data_ret, next_data_ret;
   logic next_rsp_data_ret;
   logic accept;
   logic collide;

   irc_dec_if dec ();

   irc_decide u_decide (
      .dec(dec)
   );

   // ------------------------------------------------------------------
   // Collision test and table query
   // ------------------------------------------------------------------
   assign in_ready = (state == ST_IDLE);
   assign accept = in_valid && in_ready;
   // Compare at granule size, only against a live request
   assign collide = out_valid && irc_pkg::same_granule(in_addr, out_addr);
   assign dec.in_type = irc_pkg::irc_txn_e'(in_type);
   assign dec.participant = participant;
   assign dec.collide = collide;
   // Forward strobe is a function of state, so it drops with the state
   assign fwd_valid = (state == ST_FWD);

   // ------------------------------------------------------------------
   // Next state
   // ------------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_fwd_type = fwd_type;
      next_fwd_addr = fwd_addr;
      next_rsp_valid = 1'b0;
      next_rsp_code = rsp_code;
      next_rsp_data_ret = 1'b0;
      next_data_ret = data_ret;
      case (state)
         ST_IDLE: begin
            if (accept) begin
               next_fwd_type = in_type;
               next_fwd_addr = in_addr;
               next_data_ret = 1'b0;
               case (dec.action)
                  irc_pkg::ACT_ERROR: begin
                     next_rsp_valid = 1'b1;
                     next_rsp_code = irc_pkg::RSP_ERROR;
                     next_state = ST_RESP;
                  end
                  irc_pkg::ACT_NOT_OWNER: begin
                     next_rsp_valid = 1'b1;
                     next_rsp_code = irc_pkg::RSP_NOT_OWNER;
                     next_state = ST_RESP;
                  end
                  irc_pkg::ACT_FWD: begin
                     next_state = ST_FWD;
                  end
                  irc_pkg::ACT_WAIT_FWD: begin
                     // A final answer in this very cycle is not lost
                     if (out_final) begin
                        next_data_ret = !out_final_retry;
                        next_state = ST_FWD;
                     end else begin
                        next_state = ST_WAIT;
                     end
                  end
                  default: begin
                     next_rsp_valid = 1'b1;
                     next_rsp_code = irc_pkg::RSP_PASS;
                     next_state = ST_RESP;
                  end
               endcase
            end
         end
         ST_WAIT: begin
            // Data goes back only when the request ended with DONE
            if (out_final) begin
               next_data_ret = !out_final_retry;
               next_state = ST_FWD;
            end else if (!out_valid) begin
               next_state = ST_FWD;
            end
         end
         ST_FWD: begin
            if (fwd_done) begin
               next_rsp_valid = 1'b1;
               next_rsp_code = irc_pkg::RSP_DONE;
               next_rsp_data_ret = data_ret;
               next_state = ST_RESP;
            end
         end
         ST_RESP: begin
            next_state = ST_IDLE;
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // ------------------------------------------------------------------
   // Registers
   // ------------------------------------------------------------------
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= ST_IDLE;
         fwd_type <= 4'h0;
         fwd_addr <= irc_pkg::ADDR_RST;
         rsp_valid <= 1'b0;
         rsp_code <= 2'h0;
         rsp_data_ret <= 1'b0;
         data_ret <= 1'b0;
      end else begin
         state <= next_state;
         fwd_type <= next_fwd_type;
         fwd_addr <= next_fwd_addr;
         rsp_valid <= next_rsp_valid;
         rsp_code <= next_rsp_code;
         rsp_data_ret <= next_rsp_data_ret;
         data_ret <= next_data_ret;
      end
   end

   // ------------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   logic hit_p, hit_n;
   assign hit_p = accept && collide && participant;
   assign hit_n = accept && collide && !participant;

   property p_no_hit_pass;
      accept && !collide |=> rsp_valid && rsp_code == irc_pkg::RSP_PASS;
   endproperty
   a_no_hit_pass: assert property (p_no_hit_pass)
      else $error("Miss not handed to normal path");

   property p_np_flush_err;
      hit_n && in_type == irc_pkg::TXN_FLUSH
         |=> rsp_valid && rsp_code == irc_pkg::RSP_ERROR;
   endproperty
   a_np_flush_err: assert property (p_np_flush_err)
      else $error("Non-participant flush hit not ERROR");

   property p_p_tlb_fwd;
      hit_p && in_type == irc_pkg::TXN_TLBSYNC
         |=> fwd_valid && fwd_type == irc_pkg::TXN_TLBSYNC && !rsp_valid;
   endproperty
   a_p_tlb_fwd: assert property (p_p_tlb_fwd)
      else $error("Participant TLB sync not forwarded");

   property p_p_ikill_fwd;
      hit_p && in_type == irc_pkg::TXN_IKILL_SHARER
         |=> fwd_valid && fwd_addr == $past(in_addr);
   endproperty
   a_p_ikill_fwd: assert property (p_p_ikill_fwd)
      else $error("Participant IKILL sharer not forwarded");

   property p_p_err;
      hit_p && (in_type == irc_pkg::TXN_IKILL_HOME ||
                in_type == irc_pkg::TXN_IO_READ_HOME)
         |=> rsp_valid && rsp_code == irc_pkg::RSP_ERROR ##1 in_ready;
   endproperty
   a_p_err: assert property (p_p_err)
      else $error("Participant home hit not ERROR");

   property p_p_not_owner;
      hit_p && (in_type == irc_pkg::TXN_IO_READ_OWNER ||
                in_type == irc_pkg::TXN_READ_TO_OWN_OWNER)
         |=> rsp_valid && rsp_code == irc_pkg::RSP_NOT_OWNER;
   endproperty
   a_p_not_owner: assert property (p_p_not_owner)
      else $error("Participant owner hit not NOT_OWNER");

   // Held back while the outstanding request still waits its answer
   property p_dkill_wait;
      (hit_p && in_type == irc_pkg::TXN_DKILL_SHARER && !out_final) ||
         (state == ST_WAIT && !out_final && out_valid)
         |=> !fwd_valid && !rsp_valid;
   endproperty
   a_dkill_wait: assert property (p_dkill_wait)
      else $error("DKILL sharer forwarded before final answer");

   property p_np_coh_err;
      hit_n && in_type == irc_pkg::TXN_DKILL_SHARER
         |=> rsp_valid && rsp_code == irc_pkg::RSP_ERROR && !fwd_valid;
   endproperty
   a_np_coh_err: assert property (p_np_coh_err)
      else $error("Non-participant coherent hit not ERROR");

   property p_np_bcast_fwd;
      hit_n && (in_type == irc_pkg::TXN_TLBIE ||
                in_type == irc_pkg::TXN_IKILL_SHARER)
         |=> fwd_valid && fwd_type == $past(in_type);
   endproperty
   a_np_bcast_fwd: assert property (p_np_bcast_fwd)
      else $error("Non-participant broadcast not forwarded");

   property p_done_after_fwd;
      rsp_valid && rsp_code == irc_pkg::RSP_DONE
         |-> $past(fwd_valid && fwd_done);
   endproperty
   a_done_after_fwd: assert property (p_done_after_fwd)
      else $error("DONE without completed forward");

   c_fwd_done: cover property (fwd_valid && fwd_done ##1 rsp_valid);
   c_dkill_data: cover property (rsp_valid && rsp_data_ret);
   c_np_error: cover property (hit_n ##1 rsp_code == irc_pkg::RSP_ERROR);
   c_not_owner: cover property (rsp_valid &&
                                rsp_code == irc_pkg::RSP_NOT_OWNER);

endmodule

// File: dv/irc_proc_model.sv
/*
 * Behavioural model of the local processor that takes forwarded
 * transactions from the resolver and reports completion.
 * Assumes one forward at a time and a delay set by the bench.
 */
`timescale 1ns/1ps
module irc_proc_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic fwd_valid,
   input wire logic [1:0] delay,
   output logic fwd_done
);
   logic [1:0] cnt;

   // ---------------------------------------------------------------
   // Completion handshake
   // ---------------------------------------------------------------
   // Done pulses for one cycle once the delay has run; low outside forwards
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt <= 2'h0;
         fwd_done <= 1'b0;
      end else if (fwd_valid && !fwd_done) begin
         if (cnt >= delay) begin
            fwd_done <= 1'b1;
            cnt <= 2'h0;
         end else begin
            cnt <= cnt + 2'h1; // Slow processor path
         end
      end else begin
         fwd_done <= 1'b0;
      end
   end
endmodule

// File: dv/io_read_home_collision_resolver_test.sv
/*
 * Self-checking bench for the collision resolver: drives transactions,
 * queues expected answers, and a monitor compares responses.
 * Assumes the processor model answers every forward.
 */
`timescale 1ns/1ps
module io_read_home_collision_resolver_test;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic participant = 1'b1;
   logic out_valid = 1'b0;
   logic [31:0] out_addr = 32'h0;
   logic out_final = 1'b0;
   logic out_final_retry = 1'b0;
   logic in_valid = 1'b0;
   logic [3:0] in_type = 4'h0;
   logic [31:0] in_addr = 32'h0;
   logic [1:0] delay = 2'h0;
   logic in_ready, fwd_valid, fwd_done, rsp_valid, rsp_data_ret;
   logic [3:0] fwd_type;
   logic [31:0] fwd_addr;
   logic [1:0] rsp_code;
   logic [2:0] exp_q[$];
   logic [2:0] e;
   logic fwd_seen = 1'b0;
   logic fwd_ok = 1'b0;
   int errors = 0;
   int n_tests = 0;
   int seed = 82;
   int cycles = 0;

   always #10 clk = ~clk;

   irc_resolver u_dut (.clk(clk), .rst_n(rst_n), .participant(participant),
      .out_valid(out_valid), .out_addr(out_addr), .out_final(out_final),
      .out_final_retry(out_final_retry), .in_valid(in_valid),
      .in_ready(in_ready), .in_type(in_type), .in_addr(in_addr),
      .fwd_valid(fwd_valid), .fwd_type(fwd_type), .fwd_addr(fwd_addr),
      .fwd_done(fwd_done), .rsp_valid(rsp_valid), .rsp_code(rsp_code),
      .rsp_data_ret(rsp_data_ret));

   irc_proc_model u_proc (.clk(clk), .rst_n(rst_n), .fwd_valid(fwd_valid),
      .delay(delay), .fwd_done(fwd_done));

   // ---------------------------------------------------------------
   // Checking helpers
   // ---------------------------------------------------------------
   task chk(input string what, input logic [31:0] seen,
            input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task wrap_up;
      $display("comparisons %0d mismatches %0d", n_tests, errors);
      if (errors == 0 && n_tests > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // Expected answer per role, code and address hit
   function automatic logic [1:0] exp_code(input logic p, input logic [3:0] t,
                                           input logic hit);
      if (!hit) return irc_pkg::RSP_PASS;
      case (t)
         4'h8, 4'h9, 4'hb: return irc_pkg::RSP_DONE;
         4'h6: if (p) return irc_pkg::RSP_DONE;
         4'h2, 4'h4, 4'he: if (p) return irc_pkg::RSP_NOT_OWNER;
         default: ;
      endcase
      return irc_pkg::RSP_ERROR;
   endfunction

   // ---------------------------------------------------------------
   // Driver: one transaction, waits for idle first
   // ---------------------------------------------------------------
   task go(input logic p, input logic ov, input logic [3:0] t,
           input logic h);
      int i;
      logic hit;
      logic rt;
      logic drop;
      i = 0;
      while (in_ready !== 1'b1 && i < 200) begin
         @(posedge clk);
         #1;
         i++;
      end
      chk("in_ready", {31'h0, in_ready}, 32'h1);
      hit = h & ov;
      rt = 1'($random(seed));
      drop = 1'($random(seed));
      participant = p;
      out_valid = ov;
      out_addr = $random(seed);
      delay = 2'($random(seed));
      in_type = t;
      // Miss lands in the neighbouring granule, the tightest miss
      in_addr = h ? {out_addr[31:5], 5'($random(seed))} : out_addr ^ 32'h20;
      in_valid = 1'b1;
      @(posedge clk);
      exp_q.push_back({~rt & ~drop & p & hit & (t == 4'h6),
                       exp_code(p, t, hit)});
      #1;
      in_valid = 1'b0;
      if (p && hit && t == 4'h6) begin
         repeat (3) @(posedge clk);
         #1;
         // Request may also vanish with no final answer: no data back
         if (drop) begin
            out_valid = 1'b0;
         end else begin
            out_final = 1'b1;
            out_final_retry = rt;
         end
         @(posedge clk);
         #1;
         out_final = 1'b0;
      end
   endtask

   // ---------------------------------------------------------------
   // Monitor: forwards and responses, sampled on the settled half
   // ---------------------------------------------------------------
   always @(negedge clk) begin
      if (!rst_n) begin
         fwd_seen = 1'b0;
         fwd_ok = 1'b0;
      end
      if (fwd_valid === 1'b1 && !fwd_seen) begin
         fwd_seen = 1'b1;
         chk("fwd_type", {28'h0, fwd_type}, {28'h0, in_type});
         chk("fwd_addr", fwd_addr, in_addr);
      end
      if (fwd_valid === 1'b1 && fwd_done === 1'b1) fwd_ok = 1'b1;
      if (rsp_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            chk("unexpected rsp", 32'h1, 32'h0);
         end else begin
            e = exp_q.pop_front();
            chk("rsp_code", {30'h0, rsp_code}, {30'h0, e[1:0]});
            chk("rsp_data_ret", {31'h0, rsp_data_ret}, {31'h0, e[2]});
            // A DONE needs a finished forward; others none
            chk("fwd before rsp", {31'h0, fwd_ok},
                {31'h0, e[1:0] == irc_pkg::RSP_DONE});
         end
         fwd_ok = 1'b0;
         fwd_seen = 1'b0;
      end
   end

   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         wrap_up();
      end
   end

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      repeat (12) @(posedge clk);
      #1;
      rst_n = 1'b1;
      // Every code in both roles, hit and miss
      for (int p = 0; p < 2; p++) begin
         for (int t = 0; t < 16; t++) begin
            for (int h = 0; h < 2; h++) begin
               go(p[0], 1'b1, t[3:0], h[0]);
            end
         end
      end
      // Random mix, outstanding request sometimes absent
      for (int k = 0; k < 60; k++) begin
         go(1'($random(seed)), 1'($random(seed)), 4'($random(seed)),
            1'($random(seed)));
      end
      // Reset in the middle of a forward
      go(1'b1, 1'b1, 4'h8, 1'b1);
      @(posedge clk);
      #1;
      rst_n = 1'b0;
      exp_q.delete();
      #1;
      chk("rst in_ready", {31'h0, in_ready}, 32'h1);
      chk("rst fwd_valid", {31'h0, fwd_valid}, 32'h0);
      chk("rst rsp_valid", {31'h0, rsp_valid}, 32'h0);
      repeat (2) @(posedge clk);
      #1;
      rst_n = 1'b1;
      go(1'b0, 1'b1, 4'hb, 1'b1);
      go(1'b0, 1'b1, 4'h6, 1'b1);
      repeat (20) @(posedge clk);
      chk("pending", exp_q.size(), 32'h0);
      wrap_up();
   end
endmodule
